// ===== cprr_pkg.sv
// package: register map, mode codes and carriers for the result register block
package cprr_pkg;

    localparam logic [7:0] CPRR_CONFIG_ADDR = 8'h00;
    localparam logic [7:0] CPRR_SHUNT_ADDR = 8'h01;
    localparam logic [7:0] CPRR_RAIL_ADDR = 8'h02;
    localparam logic [7:0] CPRR_WATTS_ADDR = 8'h03;
    localparam logic [7:0] CPRR_AMPS_ADDR = 8'h04;
    localparam logic [7:0] CPRR_CALIB_ADDR = 8'h05;

    localparam int CPRR_MODE_LSB = 0;
    localparam int CPRR_SIGN_BIT = 15;
    localparam int CPRR_AVG_LSB = 9;
    localparam int CPRR_SOFT_RESET_BIT = 15;
    localparam logic [15:0] CPRR_CONFIG_RESET = 16'h4127;
    localparam logic [15:0] CPRR_RESULT_RESET = 16'h0000;
    localparam logic [15:0] CPRR_CALIB_RESET = 16'h0000;
    localparam logic [15:0] CPRR_CONFIG_WMASK = 16'h0FFF;
    localparam logic [15:0] CPRR_CALIB_WMASK = 16'h7FFF;
    localparam logic [15:0] CPRR_RAIL_MASK = 16'h7FFF;
    localparam logic [15:0] CPRR_WATTS_SCALE = 16'h0019;
    localparam int CPRR_MUL_SHIFT = 11;

    typedef enum logic [2:0] {
        CPRR_MODE_OFF0 = 3'h0,
        CPRR_MODE_TRIG_SHUNT = 3'h1,
        CPRR_MODE_TRIG_RAIL = 3'h2,
        CPRR_MODE_TRIG_BOTH = 3'h3,
        CPRR_MODE_OFF4 = 3'h4,
        CPRR_MODE_CONT_SHUNT = 3'h5,
        CPRR_MODE_CONT_RAIL = 3'h6,
        CPRR_MODE_CONT_BOTH = 3'h7
    } cprr_mode_t;

    // one finished conversion from the front end
    typedef struct packed {
        logic shunt_valid;
        logic rail_valid;
        logic [15:0] shunt_drop_reading;
        logic [15:0] supply_rail_reading;
    } cprr_sample_t;

    // register access port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } cprr_req_t;

endpackage : cprr_pkg

// ===== cprr_math.sv
// combinational current and power arithmetic with overflow detection
`timescale 1ns/1ps
module cprr_math
    import cprr_pkg::*;
(
    input wire logic [15:0] shunt_i,
    input wire logic [15:0] calib_i,
    input wire logic [15:0] rail_i,
    input wire logic [15:0] amps_i,
    output logic [15:0] amps_o,
    output logic amps_ovf_o,
    output logic [15:0] watts_o,
    output logic watts_ovf_o
);
    logic signed [32:0] amps_full;
    logic signed [32:0] amps_scaled;
    logic [31:0] amps_mag;
    logic [47:0] watts_full;
    logic [47:0] watts_scaled;

    always_comb begin
        // calibration bit 15 never enters the product
        amps_full = 33'($signed(shunt_i)) * $signed({18'h0_0000, calib_i[14:0]}); // RULE11 RULE14
        amps_scaled = amps_full >>> CPRR_MUL_SHIFT;
        amps_o = amps_scaled[15:0];
        amps_ovf_o = (amps_scaled > 33'sd32767) || (amps_scaled < -33'sd32768); // RULE13
        amps_mag = amps_i[CPRR_SIGN_BIT] ? 32'(-$signed(amps_i)) : {16'h0000, amps_i};
        // power uses the magnitude so it can never read negative
        watts_full = 48'(amps_mag) * 48'(rail_i & CPRR_RAIL_MASK) * 48'(CPRR_WATTS_SCALE);
        watts_scaled = watts_full >> (CPRR_MUL_SHIFT + 4);
        watts_o = watts_scaled[15:0]; // RULE10
        watts_ovf_o = |watts_scaled[47:16]; // RULE13
    end
endmodule : cprr_math

// ===== cprr_result_regs.sv
// result registers, mode decode and register port of the current and power monitor
// Notes on behaviour
// RULE1: codes 000 and 100 mean shutdown
// RULE2: 001/010/011 trigger shunt, rail, both
// RULE3: 101/110/111 continuous; 111 after reset
// RULE4: shunt result at 01h, two's complement
// RULE5: shunt bit 15 is the sign
// RULE6: shunt lsb 2.5 uV, 32767 full scale
// RULE7: averaged values stored when averaging enabled
// RULE8: rail result at 02h, 1.25 mV lsb
// RULE9: rail result bit 15 reads zero
// RULE10: power at 03h, unsigned, never negative
// RULE11: current is shunt times calibration, signed
// RULE12: power recomputed after each rail sample
// RULE13: arithmetic overflow sets overflow flag
// RULE14: calibration bit 15 reads zero
// RULE15: triggered mode: one set, then idle
`timescale 1ns/1ps
module cprr_result_regs
    import cprr_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire cprr_req_t req_i,
    input wire cprr_sample_t sample_i,
    output logic [15:0] rdata_o,
    output logic rvalid_o,
    output logic shunt_req_o,
    output logic rail_req_o,
    output logic [2:0] avg_sel_o,
    output logic arith_overflow_flag_o,
    output logic busy_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_SHUNT, ST_RAIL, ST_CALC} cprr_seq_t;

    typedef struct packed {
        logic [15:0] config_reg;
        logic [15:0] calib_reg;
        logic [15:0] shunt_reg;
        logic [15:0] rail_reg;
        logic [15:0] amps_reg;
        logic [15:0] watts_reg;
        logic ovf_reg;
        logic trig_pend_reg;
        cprr_seq_t seq_reg;
        logic [15:0] rdata_reg;
        logic rvalid_reg;
        logic shunt_req_reg;
        logic rail_req_reg;
        logic busy_reg;
    } cprr_state_t;

    cprr_state_t st_reg;
    cprr_state_t st_next;

    logic [15:0] amps_calc;
    logic [15:0] watts_calc;
    logic amps_ovf;
    logic watts_ovf;
    logic [2:0] mode_bits;
    logic run_shunt;
    logic run_rail;
    logic continuous;
    logic power_step;
    logic soft_reset;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic wants_shunt(input logic [2:0] m);
        return m[0]; // RULE2 RULE3
    endfunction : wants_shunt

    function automatic logic wants_rail(input logic [2:0] m);
        return m[1]; // RULE2 RULE3
    endfunction : wants_rail

    assign mode_bits = st_reg.config_reg[CPRR_MODE_LSB +: 3];
    // 000 and 100 select nothing, so no conversion starts
    assign run_shunt = wants_shunt(mode_bits); // RULE1
    assign run_rail = wants_rail(mode_bits); // RULE1
    assign continuous = mode_bits[2];
    // in modes that measure the rail, power is stored in the idle cycle that follows the current update
    assign power_step = (st_reg.seq_reg == ST_IDLE) && !st_reg.shunt_req_reg && run_rail;
    assign soft_reset = req_i.wr && (req_i.addr == CPRR_CONFIG_ADDR) && req_i.wdata[CPRR_SOFT_RESET_BIT];

    cprr_math u_math (
        .shunt_i(st_reg.shunt_reg),
        .calib_i(st_reg.calib_reg),
        .rail_i(st_reg.rail_reg),
        .amps_i(st_reg.amps_reg),
        .amps_o(amps_calc),
        .amps_ovf_o(amps_ovf),
        .watts_o(watts_calc),
        .watts_ovf_o(watts_ovf)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.rvalid_reg = 1'b0;
        st_next.shunt_req_reg = 1'b0;
        st_next.rail_req_reg = 1'b0;

        unique case (st_reg.seq_reg)
            ST_IDLE: begin
                if ((continuous || st_reg.trig_pend_reg) && (run_shunt || run_rail)) begin // RULE15
                    st_next.trig_pend_reg = 1'b0;
                    if (run_shunt) begin
                        st_next.seq_reg = ST_SHUNT;
                        st_next.shunt_req_reg = 1'b1;
                    end else begin
                        st_next.seq_reg = ST_RAIL;
                        st_next.rail_req_reg = 1'b1;
                    end
                end
            end
            ST_SHUNT: begin
                if (sample_i.shunt_valid) begin
                    // front end delivers the averaged value already
                    st_next.shunt_reg = sample_i.shunt_drop_reading; // RULE4 RULE5 RULE6 RULE7
                    if (run_rail) begin
                        st_next.seq_reg = ST_RAIL;
                        st_next.rail_req_reg = 1'b1;
                    end else begin
                        st_next.seq_reg = ST_CALC;
                    end
                end
            end
            ST_RAIL: begin
                if (sample_i.rail_valid) begin
                    st_next.rail_reg = sample_i.supply_rail_reading & CPRR_RAIL_MASK; // RULE8 RULE9 RULE7
                    st_next.seq_reg = ST_CALC;
                end
            end
            ST_CALC: begin
                st_next.amps_reg = amps_calc; // RULE11
                st_next.ovf_reg = st_reg.ovf_reg | amps_ovf; // RULE13
                st_next.seq_reg = ST_IDLE;
            end
        endcase

        // in modes that measure the rail, power follows the freshly stored current, one cycle after it
        if (power_step) begin
            st_next.watts_reg = watts_calc; // RULE12
            st_next.ovf_reg = st_next.ovf_reg | watts_ovf; // RULE13
        end

        if (req_i.wr) begin
            unique case (req_i.addr)
                CPRR_CONFIG_ADDR: begin
                    if (req_i.wdata[CPRR_SOFT_RESET_BIT]) begin
                        st_next = '0;
                        st_next.config_reg = CPRR_CONFIG_RESET; // RULE3
                        st_next.seq_reg = ST_IDLE;
                    end else begin
                        st_next.config_reg = req_i.wdata & CPRR_CONFIG_WMASK;
                        st_next.trig_pend_reg = ~req_i.wdata[CPRR_MODE_LSB + 2]; // RULE15
                        st_next.seq_reg = ST_IDLE;
                        // an aborted sequence must not leave a start pulse behind
                        st_next.shunt_req_reg = 1'b0;
                        st_next.rail_req_reg = 1'b0;
                    end
                end
                CPRR_CALIB_ADDR: st_next.calib_reg = req_i.wdata & CPRR_CALIB_WMASK; // RULE14
                default: begin
                end
            endcase
        end

        if (req_i.rd) begin
            st_next.rvalid_reg = 1'b1;
            unique case (req_i.addr)
                CPRR_CONFIG_ADDR: st_next.rdata_reg = st_reg.config_reg;
                CPRR_SHUNT_ADDR: st_next.rdata_reg = st_reg.shunt_reg; // RULE4
                CPRR_RAIL_ADDR: st_next.rdata_reg = st_reg.rail_reg; // RULE9
                CPRR_WATTS_ADDR: st_next.rdata_reg = st_reg.watts_reg; // RULE10
                CPRR_AMPS_ADDR: st_next.rdata_reg = st_reg.amps_reg;
                CPRR_CALIB_ADDR: st_next.rdata_reg = st_reg.calib_reg; // RULE14
                default: st_next.rdata_reg = CPRR_RESULT_RESET;
            endcase
        end

        // registered, so busy_o needs no decode after the flip-flops
        st_next.busy_reg = (st_next.seq_reg != ST_IDLE);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_reg <= '0;
            st_reg.config_reg <= CPRR_CONFIG_RESET; // RULE3
            st_reg.calib_reg <= CPRR_CALIB_RESET;
            st_reg.seq_reg <= ST_IDLE;
        end else if (ce_i) begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rdata_o = st_reg.rdata_reg;
    assign rvalid_o = st_reg.rvalid_reg;
    assign shunt_req_o = st_reg.shunt_req_reg;
    assign rail_req_o = st_reg.rail_req_reg;
    assign avg_sel_o = st_reg.config_reg[CPRR_AVG_LSB +: 3];
    assign arith_overflow_flag_o = st_reg.ovf_reg;
    assign busy_o = st_reg.busy_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence shunt_seen;
        ce_i && st_reg.seq_reg == ST_SHUNT && sample_i.shunt_valid && !req_i.wr;
    endsequence

    shutdown_idle_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RULE1
        (mode_bits[1:0] == 2'b00 && st_reg.seq_reg == ST_IDLE) |=> !shunt_req_o && !rail_req_o)
        else $error("conversion started in shutdown");
    shunt_store_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RULE4
        shunt_seen |=> st_reg.shunt_reg == $past(sample_i.shunt_drop_reading))
        else $error("shunt sample not stored");
    rail_bit15_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RULE9
        !st_reg.rail_reg[15]) else $error("rail bit 15 set");
    calib_bit15_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RULE14
        !st_reg.calib_reg[15]) else $error("calibration bit 15 set");
    calc_amps_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RULE11
        (ce_i && st_reg.seq_reg == ST_CALC && !req_i.wr) |=> st_reg.amps_reg == $past(amps_calc))
        else $error("current not updated");
    trig_once_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RULE15
        (ce_i && st_reg.seq_reg == ST_CALC && !continuous && !req_i.wr) |=> !st_reg.trig_pend_reg)
        else $error("triggered mode repeats");
    ovf_set_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RULE13
        (ce_i && st_reg.seq_reg == ST_CALC && amps_ovf && !req_i.wr) |=> arith_overflow_flag_o)
        else $error("overflow flag missed");
    rail_path_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RULE2
        shunt_seen ##0 (!run_rail) |=> st_reg.seq_reg == ST_CALC)
        else $error("rail measured in shunt-only mode");

    sequence rail_seen;
        ce_i && st_reg.seq_reg == ST_RAIL && sample_i.rail_valid && !req_i.wr;
    endsequence

    sequence calc_seen;
        ce_i && st_reg.seq_reg == ST_CALC && !req_i.wr;
    endsequence

    sequence quiet_step;
        ce_i && !req_i.wr;
    endsequence

    soft_reset_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RULE3
        (ce_i && soft_reset) |=> st_reg.config_reg == CPRR_CONFIG_RESET && !arith_overflow_flag_o)
        else $error("soft reset left state behind");
    cont_start_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RULE3
        (ce_i && !req_i.wr && st_reg.seq_reg == ST_IDLE && continuous && (run_shunt || run_rail))
            |=> busy_o && (shunt_req_o || rail_req_o))
        else $error("continuous mode did not restart");
    trig_start_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RULE2
        (ce_i && !req_i.wr && st_reg.seq_reg == ST_IDLE && !continuous && st_reg.trig_pend_reg && run_shunt)
            |=> shunt_req_o && !rail_req_o)
        else $error("triggered start missing");
    rail_only_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RULE2
        (ce_i && !req_i.wr && st_reg.seq_reg == ST_IDLE && !run_shunt && run_rail
            && (continuous || st_reg.trig_pend_reg)) |=> rail_req_o && !shunt_req_o)
        else $error("rail-only mode started a shunt conversion");
    rail_store_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RULE8
        rail_seen |=> st_reg.rail_reg == ($past(sample_i.supply_rail_reading) & CPRR_RAIL_MASK))
        else $error("rail sample not stored");
    watts_follow_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RULE12
        (calc_seen ##0 run_rail) ##1 quiet_step |=> st_reg.watts_reg == $past(watts_calc))
        else $error("power not updated after rail sample");
    trig_rest_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RULE15
        (calc_seen ##0 !continuous) ##1 quiet_step |=> !shunt_req_o && !rail_req_o && !busy_o)
        else $error("triggered mode did not come to rest");
    ovf_sticky_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RULE13
        (arith_overflow_flag_o && !soft_reset) |=> arith_overflow_flag_o)
        else $error("overflow flag dropped");
    ovf_watts_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RULE13
        (ce_i && power_step && watts_ovf && !soft_reset) |=> arith_overflow_flag_o)
        else $error("power overflow missed");
    cfg_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RULE1
        (ce_i && req_i.rd && req_i.addr == CPRR_CONFIG_ADDR) |=> rvalid_o && rdata_o == $past(st_reg.config_reg))
        else $error("configuration read wrong");
    shunt_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RULE4
        (ce_i && req_i.rd && req_i.addr == CPRR_SHUNT_ADDR) |=> rvalid_o && rdata_o == $past(st_reg.shunt_reg))
        else $error("shunt read wrong");
    rail_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RULE9
        (ce_i && req_i.rd && req_i.addr == CPRR_RAIL_ADDR) |=> rvalid_o && !rdata_o[CPRR_SIGN_BIT])
        else $error("rail read shows bit 15");
    ce_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        !ce_i |=> $stable(st_reg))
        else $error("state moved while clock enable low");
endmodule : cprr_result_regs

// ===== cprr_front_model.sv
// front-end conversion model answering each start request with a finished sample
`timescale 1ns/1ps
module cprr_front_model
    import cprr_pkg::*;
#(
    parameter int DELAY = 40
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic shunt_req_i,
    input wire logic rail_req_i,
    input wire logic [15:0] shunt_val_i,
    input wire logic [15:0] rail_val_i,
    output cprr_sample_t sample_o
);
    // ----------------------------------------
    // conversion delay counters
    // ----------------------------------------
    int s_cnt;
    int r_cnt;
    // inverted data outside the valid cycle, so a late capture shows up
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_cnt <= 0;
            r_cnt <= 0;
            sample_o <= '0;
        end else begin
            s_cnt <= shunt_req_i ? DELAY : (s_cnt > 0 ? s_cnt - 1 : 0);
            r_cnt <= rail_req_i ? DELAY : (r_cnt > 0 ? r_cnt - 1 : 0);
            sample_o.shunt_valid <= (s_cnt == 1);
            sample_o.rail_valid <= (r_cnt == 1);
            sample_o.shunt_drop_reading <= (s_cnt == 1) ? shunt_val_i : ~shunt_val_i;
            sample_o.supply_rail_reading <= (r_cnt == 1) ? rail_val_i : ~rail_val_i;
        end
    end
endmodule : cprr_front_model

// ===== cprr_result_regs_tb_top.sv
// testbench: register reads, mode sequencing and arithmetic of the result block
`timescale 1ns/1ps
module cprr_result_regs_tb_top;
    import cprr_pkg::*;
    logic clk_sys_i;
    logic rstn_i;
    logic ce_i;
    cprr_req_t req;
    cprr_sample_t smp;
    logic [15:0] rdata;
    logic [15:0] shv;
    logic [15:0] rlv;
    logic rvalid, sreq, rreq, ovf, busy;
    logic [2:0] avg;
    int n_mismatch = 0;
    int checked = 0;
    int n_sreq, n_rreq;
    // capped start counts per mode code: 2 means repeating
    int exp_s [8] = '{0, 1, 0, 1, 0, 2, 0, 2};
    int exp_r [8] = '{0, 0, 1, 1, 0, 0, 2, 2};

    cprr_result_regs dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce_i), .req_i(req), .sample_i(smp),
        .rdata_o(rdata), .rvalid_o(rvalid), .shunt_req_o(sreq), .rail_req_o(rreq), .avg_sel_o(avg),
        .arith_overflow_flag_o(ovf), .busy_o(busy));
    cprr_front_model #(.DELAY(40)) fe (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .shunt_req_i(sreq),
        .rail_req_i(rreq), .shunt_val_i(shv), .rail_val_i(rlv), .sample_o(smp));

    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    // counted mid-cycle, away from the edge that launches the pulses
    always @(negedge clk_sys_i) begin
        n_sreq += int'(sreq);
        n_rreq += int'(rreq);
    end

    // ----------------------------------------
    // access and check tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= d;
        @(posedge clk_sys_i);
        req.wr <= 1'b0;
        @(posedge clk_sys_i);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string name);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge clk_sys_i);
        req.rd <= 1'b0;
        #1;
        chk({name, " valid"}, {15'h0000, rvalid}, 16'h0001);
        chk(name, rdata, exp);
        @(posedge clk_sys_i);
    endtask : rd
    // waits for n rail samples, then for the current and power updates
    task automatic wait_rail(input int n);
        int i;
        i = 0;
        while (n > 0 && i < 1000) begin
            @(negedge clk_sys_i);
            if (smp.rail_valid === 1'b1) n--;
            i++;
        end
        chk("rail wait", 16'(n), 16'h0000);
        repeat (4) @(posedge clk_sys_i);
    endtask : wait_rail
    task automatic finish_test;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        rstn_i = 1'b0;
        ce_i = 1'b1;
        req = '0;
        shv = 16'h8300;
        rlv = 16'h8010;
        repeat (4) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        @(posedge clk_sys_i);
        rd(8'h00, 16'h4127, "config");
        rd(8'h01, 16'h0000, "shunt rst");
        rd(8'h02, 16'h0000, "rail rst");
        rd(8'h04, 16'h0000, "amps rst");
        rd(8'h05, 16'h0000, "calib rst");
        rd(8'h10, 16'h0000, "unmapped");
        wr(8'h05, 16'hFFFF);
        rd(8'h05, 16'h7FFF, "calib top");
        wr(8'h01, 16'h1234);
        // calibration 2048 makes current equal to shunt: -32000 -> 8300
        wr(8'h05, 16'h0800);
        wait_rail(2);
        rd(8'h01, 16'h8300, "shunt neg");
        rd(8'h02, 16'h0010, "rail sign");
        rd(8'h04, 16'h8300, "amps");
        // 32000 * 16 * 25 >> 15 = 390
        rd(8'h03, 16'h0186, "watts");
        rlv <= 16'h0020;
        wait_rail(2);
        // 32000 * 32 * 25 >> 15 = 781
        rd(8'h03, 16'h030D, "watts new");
        chk("ovf clear", {15'h0000, ovf}, 16'h0000);
        wr(8'h05, 16'h7FFF);
        wait_rail(1);
        chk("ovf set", {15'h0000, ovf}, 16'h0001);
        wr(8'h00, 16'h8000);
        chk("ovf soft", {15'h0000, ovf}, 16'h0000);
        rd(8'h05, 16'h0000, "calib soft");
        rd(8'h00, 16'h4127, "config soft");
        for (int m = 0; m < 8; m++) begin
            wr(8'h00, {13'h0000, 3'(m)});
            n_sreq = 0;
            n_rreq = 0;
            repeat (300) @(posedge clk_sys_i);
            chk("shunt starts", 16'(n_sreq > 1 ? 2 : n_sreq), 16'(exp_s[m]));
            chk("rail starts", 16'(n_rreq > 1 ? 2 : n_rreq), 16'(exp_r[m]));
            if (m < 5) chk("idle", {15'h0000, busy}, 16'h0000);
        end
        wr(8'h00, 16'h0A07);
        chk("avg sel", {13'h0000, avg}, 16'h0005);
        // a write while the clock enable is low must be lost
        ce_i <= 1'b0;
        wr(8'h00, 16'h0004);
        ce_i <= 1'b1;
        rd(8'h00, 16'h0A07, "frozen cfg");
        finish_test();
    end

    initial begin
        #(20000 * 8);
        n_mismatch++;
        finish_test();
    end
endmodule : cprr_result_regs_tb_top
